/* File: rtl/stc_pkg.sv */
// Purpose: shared constants for the sram traffic checker
// Assumes: one clock domain, the pll system clock
// Notes:   address width and lane count are defaults the top module parameterises; lane width stays 8
package stc_pkg;
	localparam int STC_ADDR_W      = 18;
	localparam int STC_LANES       = 4;
	localparam int STC_LANE_W      = 8;
	localparam int STC_DATA_W      = STC_LANES * STC_LANE_W;
	localparam logic [STC_ADDR_W-1:0] STC_LAST_ADDR = 18'h0000F;
	// seed of lane n is base + n * step, so all lanes differ
	localparam logic [7:0] STC_SEED_BASE = 8'h11;
	localparam logic [7:0] STC_SEED_STEP = 8'h35;
	localparam int STC_RST_SYNC_STAGES = 2;

	typedef enum logic [2:0]
	{
		STC_IDLE  = 3'b000,
		STC_WRITE = 3'b001,
		STC_READ  = 3'b010,
		STC_DRAIN = 3'b011,
		STC_DONE  = 3'b100
	} stc_state_e;

	function automatic logic [7:0] stc_seed(input int lane);
		stc_seed = STC_SEED_BASE + 8'(lane) * STC_SEED_STEP;
	endfunction
endpackage

/* File: rtl/stc_reset_seq.sv */
// Purpose: core reset from board reset and pll lock
// Assumes: pll_locked_i is synchronous to the pll system clock
// Notes:   released through a short synchroniser, asserted at once
`timescale 1ns/1ps
module stc_reset_seq
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic pll_locked_i,
	output logic      core_rst_n_o
);
	import stc_pkg::*;

	logic [STC_RST_SYNC_STAGES-1:0] sync_q;
	logic [STC_RST_SYNC_STAGES-1:0] sync_d;
	logic                           arst_n;

	// board reset low or lock lost clears everything immediately
	assign arst_n = rst_n_i & pll_locked_i;

	always_comb
	begin
		sync_d = {sync_q[STC_RST_SYNC_STAGES-2:0], 1'b1};
	end

	always_ff @(posedge clk_i or negedge arst_n)
	begin
		if (!arst_n)
			sync_q <= '0;
		else
			sync_q <= sync_d;
	end

	assign core_rst_n_o = sync_q[STC_RST_SYNC_STAGES-1];
endmodule

/* File: rtl/stc_sram_traffic_checker.sv */
// Purpose: self-checking traffic generator plus reset sequencing
// Assumes: clk_i is the pll system clock shared with the controller
// Notes:   one pass over the address range, then rests in done
`timescale 1ns/1ps
module stc_sram_traffic_checker
#(
	parameter int ADDR_W = stc_pkg::STC_ADDR_W,
	parameter int LANES  = stc_pkg::STC_LANES
)
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  pll_locked_i,
	input  wire logic                  training_done_i,
	input  wire logic                  wr_stall_i,
	input  wire logic                  rd_stall_i,
	input  wire logic                  rd_valid_i,
	input  wire logic [LANES*8-1:0]    rd_data_i,
	output logic                       pll_rst_o,
	output logic                       core_rst_n_o,
	output logic                       wr_req_o,
	output logic                       wr_cs_o,
	output logic [ADDR_W-1:0]          wr_addr_o,
	output logic [LANES*8-1:0]         wr_data_o,
	output logic [LANES-1:0]           wr_byte_en_n_o,
	output logic                       rd_req_o,
	output logic                       rd_cs_o,
	output logic [ADDR_W-1:0]          rd_addr_o,
	output logic [LANES-1:0]           rd_byte_en_n_o,
	output logic                       fail_o,
	output logic                       fail_sticky_o,
	output logic                       done_o
);
	import stc_pkg::*;

	localparam int DW = LANES * 8;

	// ************************************************************
	// reset sequencing
	// ************************************************************
	logic core_rst_n;
	logic pll_rst_q;

	stc_reset_seq u_rst
	(
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.pll_locked_i (pll_locked_i),
		.core_rst_n_o (core_rst_n)
	);

	// pll held while board reset is low; the pll may run without clk
	// so this flop sets asynchronously and clears on the first edge
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pll_rst_q <= 1'b1;
		else
			pll_rst_q <= 1'b0;
	end

	assign pll_rst_o    = pll_rst_q;
	assign core_rst_n_o = core_rst_n;

	// ************************************************************
	// traffic generator
	// ************************************************************
	stc_state_e        state_q, state_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [ADDR_W-1:0] raddr_q, raddr_d;
	logic [ADDR_W-1:0] cnt_q, cnt_d;
	logic [DW-1:0]     wpat_q, wpat_d;
	logic [DW-1:0]     epat_q, epat_d;
	logic              wreq_q, wreq_d;
	logic              rreq_q, rreq_d;
	logic              fail_q, fail_d;
	logic              sticky_q, sticky_d;
	logic              done_q, done_d;
	logic              mismatch;

	function automatic logic [DW-1:0] seeds();
		logic [DW-1:0] s;
		s = '0;
		for (int i = 0; i < LANES; i++)
			s[i*8 +: 8] = stc_seed(i);
		return s;
	endfunction

	// folded to a constant so the async reset branch loads a fixed value
	localparam logic [DW-1:0] SEED_PAT = seeds();

	function automatic logic [DW-1:0] bump(input logic [DW-1:0] p);
		logic [DW-1:0] n;
		n = '0;
		for (int i = 0; i < LANES; i++)
			n[i*8 +: 8] = p[i*8 +: 8] + 8'h01;
		return n;
	endfunction

	assign mismatch = rd_valid_i && (rd_data_i != epat_q);

	always_comb
	begin
		state_d  = state_q;
		waddr_d  = waddr_q;
		raddr_d  = raddr_q;
		cnt_d    = cnt_q;
		wpat_d   = wpat_q;
		epat_d   = epat_q;
		wreq_d   = wreq_q;
		rreq_d   = rreq_q;
		fail_d   = mismatch;
		sticky_d = sticky_q | mismatch;
		done_d   = done_q;
		if (rd_valid_i)
		begin
			epat_d = bump(epat_q);
			cnt_d  = cnt_q + 1'b1;
		end
		unique case (state_q)
			STC_IDLE:
				if (training_done_i)
				begin
					state_d = STC_WRITE;
					wreq_d  = 1'b1;
				end
			STC_WRITE:
				if (!wr_stall_i)
				begin
					wpat_d = bump(wpat_q);
					if (waddr_q == STC_LAST_ADDR[ADDR_W-1:0])
					begin
						wreq_d  = 1'b0;
						rreq_d  = 1'b1;
						state_d = STC_READ;
					end
					else
						waddr_d = waddr_q + 1'b1;
				end
			STC_READ:
				if (!rd_stall_i)
				begin
					if (raddr_q == STC_LAST_ADDR[ADDR_W-1:0])
					begin
						rreq_d  = 1'b0;
						state_d = STC_DRAIN;
					end
					else
						raddr_d = raddr_q + 1'b1;
				end
			STC_DRAIN:
				if (rd_valid_i && cnt_q == STC_LAST_ADDR[ADDR_W-1:0])
				begin
					state_d = STC_DONE;
					done_d  = 1'b1;
				end
			STC_DONE:
				state_d = STC_DONE;
			default:
				state_d = STC_IDLE;
		endcase
	end

	// core reset covers the generator, so lock loss restarts it
	always_ff @(posedge clk_i or negedge core_rst_n)
	begin
		if (!core_rst_n)
		begin
			state_q  <= STC_IDLE;
			waddr_q  <= '0;
			raddr_q  <= '0;
			cnt_q    <= '0;
			wpat_q   <= SEED_PAT;
			epat_q   <= SEED_PAT;
			wreq_q   <= 1'b0;
			rreq_q   <= 1'b0;
			fail_q   <= 1'b0;
			sticky_q <= 1'b0;
			done_q   <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			waddr_q  <= waddr_d;
			raddr_q  <= raddr_d;
			cnt_q    <= cnt_d;
			wpat_q   <= wpat_d;
			epat_q   <= epat_d;
			wreq_q   <= wreq_d;
			rreq_q   <= rreq_d;
			fail_q   <= fail_d;
			sticky_q <= sticky_d;
			done_q   <= done_d;
		end
	end

	assign wr_req_o       = wreq_q;
	assign wr_cs_o        = wreq_q;
	assign wr_addr_o      = waddr_q;
	assign wr_data_o      = wpat_q;
	assign wr_byte_en_n_o = '0;
	assign rd_req_o       = rreq_q;
	assign rd_cs_o        = rreq_q;
	assign rd_addr_o      = raddr_q;
	assign rd_byte_en_n_o = '0;
	assign fail_o         = fail_q;
	assign fail_sticky_o  = sticky_q;
	assign done_o         = done_q;

	// ************************************************************
	// checks
	// ************************************************************
	property p_fail_pulse;
		@(posedge clk_i) disable iff (!core_rst_n)
		mismatch |=> fail_o;
	endproperty
	a_fail_pulse: assert property (p_fail_pulse) else $error("fail missed");

	property p_fail_cause;
		@(posedge clk_i) disable iff (!core_rst_n)
		fail_o |-> $past(mismatch);
	endproperty
	a_fail_cause: assert property (p_fail_cause) else $error("fail no cause");

	property p_sticky;
		@(posedge clk_i) disable iff (!core_rst_n)
		fail_sticky_o |=> fail_sticky_o;
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky dropped");

	property p_sticky_set;
		@(posedge clk_i) disable iff (!core_rst_n)
		fail_o |-> fail_sticky_o;
	endproperty
	a_sticky_set: assert property (p_sticky_set) else $error("sticky not set");

	property p_wr_hold;
		@(posedge clk_i) disable iff (!core_rst_n)
		wr_req_o && wr_stall_i |=> wr_req_o && $stable(wr_addr_o) && $stable(wr_data_o);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write moved in stall");

	property p_rd_hold;
		@(posedge clk_i) disable iff (!core_rst_n)
		rd_req_o && rd_stall_i |=> rd_req_o && $stable(rd_addr_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read moved in stall");

	property p_no_rw_overlap;
		@(posedge clk_i) disable iff (!core_rst_n)
		rd_req_o |-> !wr_req_o;
	endproperty
	a_no_rw_overlap: assert property (p_no_rw_overlap) else $error("read during write");

	property p_wait_training;
		@(posedge clk_i) disable iff (!core_rst_n)
		$rose(wr_req_o) |-> $past(training_done_i);
	endproperty
	a_wait_training: assert property (p_wait_training) else $error("early start");

	property p_byte_en;
		@(posedge clk_i) disable iff (!core_rst_n)
		wr_byte_en_n_o == '0 && rd_byte_en_n_o == '0;
	endproperty
	a_byte_en: assert property (p_byte_en) else $error("byte enables off");

	property p_pat_step;
		@(posedge clk_i) disable iff (!core_rst_n)
		rd_valid_i |=> epat_q[7:0] == $past(epat_q[7:0]) + 8'h01;
	endproperty
	a_pat_step: assert property (p_pat_step) else $error("pattern step");

	c_write_done: cover property (@(posedge clk_i) disable iff (!core_rst_n) $rose(rd_req_o));
	c_fail:       cover property (@(posedge clk_i) disable iff (!core_rst_n) fail_o);
	c_wr_stall:   cover property (@(posedge clk_i) disable iff (!core_rst_n) wr_req_o && wr_stall_i);
	c_done:       cover property (@(posedge clk_i) disable iff (!core_rst_n) $rose(done_o));
endmodule

/* File: verif/stc_ctrl_model.sv */
// Purpose: behavioural controller local ports facing the traffic checker
// Assumes: one clock; a request is taken only on an unstalled edge
// Notes:   reads answer one cycle after being taken
`timescale 1ns/1ps
module stc_ctrl_model
(
	input  wire logic        clk_i,
	input  wire logic        slow_i,
	input  wire logic        corrupt_i,
	input  wire logic [1:0]  rnd_i,
	input  wire logic        wr_req_i,
	input  wire logic        wr_cs_i,
	input  wire logic [17:0] wr_addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic [3:0]  wr_byte_en_n_i,
	input  wire logic        rd_req_i,
	input  wire logic        rd_cs_i,
	input  wire logic [17:0] rd_addr_i,
	output logic             wr_stall_o,
	output logic             rd_stall_o,
	output logic             rd_valid_o,
	output logic [31:0]      rd_data_o
);
	logic [31:0] mem [int];
	logic [31:0] pipe [$];
	logic [1:0]  stall_pick;
	initial
	begin
		wr_stall_o = 1'b0;
		rd_stall_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_data_o  = 32'h0;
	end
	always @(posedge clk_i)
	begin
		// random bits come from the seeded bench thread, taken before it moves them
		stall_pick = rnd_i;
		if (wr_req_i && wr_cs_i && !wr_stall_o)
			for (int n = 0; n < 4; n++)
				if (!wr_byte_en_n_i[n])
					mem[wr_addr_i][8*n+:8] = wr_data_i[8*n+:8];
		if (rd_req_i && rd_cs_i && !rd_stall_o)
			pipe.push_back(mem[rd_addr_i] ^ {31'h0, corrupt_i && rd_addr_i == 18'h5});
		#1;
		wr_stall_o = slow_i && stall_pick[0];
		rd_stall_o = slow_i && stall_pick[1];
		rd_valid_o = pipe.size() > 0;
		// data is inverted while no word is released so stale words never look valid
		rd_data_o = rd_valid_o ? pipe.pop_front() : ~rd_data_o;
	end
endmodule

/* File: verif/sram_traffic_checker_tb_top.sv */
// Purpose: self-checking bench for the sram traffic checker
// Assumes: default widths, 16 locations
// Notes:   two passes, the second with stalls and one bad word
`timescale 1ns/1ps
module sram_traffic_checker_tb_top;
	import stc_pkg::*;
	logic clk_i = 0, rst_n_i = 0, pll_locked_i = 0, training_done_i = 0, slow = 0, corrupt = 0;
	logic wr_stall_i, rd_stall_i, rd_valid_i, pll_rst_o, core_rst_n_o, wr_req_o, wr_cs_o;
	logic rd_req_o, rd_cs_o, fail_o, fail_sticky_o, done_o;
	logic [31:0] rd_data_i, wr_data_o, wd;
	logic [17:0] wr_addr_o, rd_addr_o, wa;
	logic [3:0]  wr_byte_en_n_o, rd_byte_en_n_o;
	int fail_count = 0, num_checks = 0, wr_i, rd_i, iss_i, k;
	logic exp_fail, exp_sticky, held;
	logic [1:0] rnd = 2'h0;
	always #50 clk_i = ~clk_i;
	stc_sram_traffic_checker u_stc_sram_traffic_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.pll_locked_i(pll_locked_i), .training_done_i(training_done_i), .wr_stall_i(wr_stall_i),
		.rd_stall_i(rd_stall_i), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
		.pll_rst_o(pll_rst_o), .core_rst_n_o(core_rst_n_o), .wr_req_o(wr_req_o),
		.wr_cs_o(wr_cs_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
		.wr_byte_en_n_o(wr_byte_en_n_o), .rd_req_o(rd_req_o), .rd_cs_o(rd_cs_o),
		.rd_addr_o(rd_addr_o), .rd_byte_en_n_o(rd_byte_en_n_o), .fail_o(fail_o),
		.fail_sticky_o(fail_sticky_o), .done_o(done_o));
	stc_ctrl_model u_stc_ctrl_model (.clk_i(clk_i), .slow_i(slow), .corrupt_i(corrupt), .rnd_i(rnd),
		.wr_req_i(wr_req_o), .wr_cs_i(wr_cs_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o),
		.wr_byte_en_n_i(wr_byte_en_n_o), .rd_req_i(rd_req_o), .rd_cs_i(rd_cs_o),
		.rd_addr_i(rd_addr_o), .wr_stall_o(wr_stall_i), .rd_stall_o(rd_stall_i),
		.rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));
	// ***************************************************************
	// reference model and checks
	// ***************************************************************
	function automatic logic [31:0] pat(input int i);
		for (int n = 0; n < 4; n++)
			pat[8*n+:8] = 8'(int'(STC_SEED_BASE) + n * int'(STC_SEED_STEP) + i);
	endfunction
	task automatic chk(input bit ok, input string msg);
		num_checks++;
		if (!ok)
		begin
			fail_count++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		if (core_rst_n_o !== 1'b1)
		begin
			wr_i = 0;
			rd_i = 0;
			iss_i = 0;
			exp_fail = 0;
			exp_sticky = 0;
			held = 0;
		end
		else
		begin
			chk(fail_o === exp_fail, "fail pulse");
			exp_sticky = exp_sticky | exp_fail;
			chk(fail_sticky_o === exp_sticky, "sticky flag");
			exp_fail = 0;
			if (held)
				chk(wr_req_o === 1'b1 && wr_addr_o === wa && wr_data_o === wd, "stall hold");
			held = wr_req_o === 1'b1 && wr_stall_i === 1'b1;
			wa = wr_addr_o;
			wd = wr_data_o;
			if (wr_req_o === 1'b1 && wr_stall_i === 1'b0)
			begin
				chk(wr_addr_o === 18'(wr_i) && wr_data_o === pat(wr_i) && rd_req_o === 1'b0
					&& wr_cs_o === 1'b1 && wr_byte_en_n_o === 4'h0, "write word");
				wr_i++;
			end
			if (rd_req_o === 1'b1 && rd_stall_i === 1'b0)
			begin
				chk(wr_i == 16 && rd_addr_o === 18'(iss_i) && rd_cs_o === 1'b1
					&& rd_byte_en_n_o === 4'h0, "read issue");
				iss_i++;
			end
			if (rd_valid_i === 1'b1)
			begin
				exp_fail = rd_data_i !== pat(rd_i);
				rd_i++;
			end
		end
	end
	// ***************************************************************
	// scenarios
	// ***************************************************************
	// stall picks are drawn here so they come from the seeded thread
	task automatic cyc(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			#1;
			rnd = 2'($urandom);
		end
	endtask
	task automatic run(input bit s, input bit c);
		slow = s;
		corrupt = c;
		rst_n_i = 0;
		pll_locked_i = 0;
		training_done_i = 0;
		cyc(8);
		chk(core_rst_n_o === 1'b0 && pll_rst_o === 1'b1 && wr_req_o === 1'b0, "held");
		rst_n_i = 1;
		cyc(4);
		chk(core_rst_n_o === 1'b0 && pll_rst_o === 1'b0, "released unlocked");
		pll_locked_i = 1;
		cyc(3);
		chk(core_rst_n_o === 1'b1, "core release");
		cyc(5);
		chk(wr_req_o === 1'b0, "start before training");
		training_done_i = 1;
		for (k = 0; k < 3000 && done_o !== 1'b1; k++)
			cyc(1);
		if (k == 3000)
		begin
			chk(1'b0, "timeout waiting for done");
			finish_test();
		end
		chk(wr_i == 16 && rd_i == 16 && fail_sticky_o === c, "end of pass");
		pll_locked_i = 0;
		#1;
		chk(core_rst_n_o === 1'b0, "lock loss");
		cyc(1);
		chk(fail_sticky_o === 1'b0 && done_o === 1'b0, "flags cleared");
		$display("test done slow=%0d corrupt=%0d", s, c);
	endtask
	initial
	begin
		void'($urandom(32'h160D02D7));
		run(0, 0);
		run(1, 1);
		finish_test();
	end
endmodule
